// file: design/pmss_core.sv
// Printer target: mode-report and print-halt command interpreter
`include "pmss_map.svh"
`default_nettype none
// How it works
// - Opcode 1Ah returns mode parameters to the initiator as DATA IN bytes.
// - Allocation length zero sends no bytes and ends with good status.
// - Nonzero length sends the smaller of allocation and available byte count.
// - Data starts with a four-byte header, then optional vendor bytes.
// - Header byte 0 counts bytes following it, not itself.
// - Policy zero holds print good status until data is physically printed.
// - Policy one gives print good status once data is buffered.
// - Policy values 2h to 7h are reserved and never given behaviour.
// - Opcode 1Bh halts printing in an orderly manner.
// - Keep bit zero discards the buffer; one keeps unprinted data.
// - Kept data may be recovered when recovery is supported.
// - Next print after a kept halt prints leftover data first.
// - The exact stop point after a halt is implementation specific.
module pmss_core #(
    parameter int VENDOR_BYTES = 0
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Command bytes from the initiator
    input wire logic [7:0] cdb_data_in,
    input wire logic cdb_valid_in,
    output logic cdb_ready_out,
    // DATA IN stream to the initiator
    output logic [7:0] din_data_out,
    output logic din_valid_out,
    input wire logic din_ready_in,
    output logic din_last_out,
    // Command completion
    output logic status_valid_out,
    output logic [7:0] status_out,
    input wire logic status_ready_in,
    // Print-acknowledge policy as set by mode-select
    input wire logic [2:0] policy_in,
    input wire logic [8*(VENDOR_BYTES+1)-1:0] vendor_bytes_in,
    // Print engine hooks
    output logic halt_out,
    output logic discard_out,
    output logic keep_out,
    output logic [2:0] policy_out,
    output logic print_ack_early_out
);
    // =====================================================================
    // Parameter checks
    // =====================================================================
    // Header plus vendor bytes must fit the one-byte length field
    if (VENDOR_BYTES < 0 || VENDOR_BYTES > 251) begin : g_bad_vendor
        $error("VENDOR_BYTES out of range");
    end

    // =====================================================================
    // Constants
    // =====================================================================
    localparam logic [7:0] AVAIL = 8'(`PMSS_HDR_LEN + VENDOR_BYTES);
    localparam logic [2:0] CDB_LAST = 3'(`PMSS_CDB_LEN - 3'd1);

    // =====================================================================
    // Functions
    // =====================================================================
    // smaller of allocation and available count
    function automatic logic [7:0] pmss_min8(
        input logic [7:0] a,
        input logic [7:0] b
    );
        logic [7:0] res;
        res = b;
        if (a < b) begin
            res = a;
        end
        return res;
    endfunction : pmss_min8

    // header bytes first, vendor bytes after
    function automatic logic [7:0] pmss_sense_byte(
        input logic [7:0] idx,
        input logic [2:0] pol,
        input logic [8*(VENDOR_BYTES+1)-1:0] vend
    );
        logic [7:0] res;
        int k;
        res = 8'h00;
        k = 0;
        case (idx)
            8'd0: begin
                res = AVAIL - 8'd1;
            end
            8'd1: begin
                res = 8'h00;
            end
            8'd2: begin
                // policy field read back as set
                res[`PMSS_POLICY_LSB +: 3] = pol;
            end
            8'd3: begin
                res = 8'h00;
            end
            default: begin
                k = int'(idx) - 4;
                res = vend[8*k +: 8];
            end
        endcase
        return res;
    endfunction : pmss_sense_byte

    // =====================================================================
    // Declarations
    // =====================================================================
    pmss_pkg::pmss_state_t state_ff;
    pmss_pkg::pmss_state_t nxt_state;
    logic [2:0] idx_ff;
    logic [2:0] nxt_idx;
    logic [7:0] op_ff;
    logic [7:0] nxt_op;
    logic [7:0] b1_ff;
    logic [7:0] nxt_b1;
    logic [7:0] alloc_ff;
    logic [7:0] nxt_alloc;
    logic [7:0] len_ff;
    logic [7:0] nxt_len;
    logic [7:0] stat_ff;
    logic [7:0] nxt_stat;
    logic [7:0] sent_ff;
    logic [7:0] nxt_sent;
    logic halt_ff;
    logic nxt_halt;
    logic discard_ff;
    logic nxt_discard;
    logic kept_ff;
    logic nxt_kept;
    logic [2:0] policy_ff;
    logic [2:0] nxt_policy;
    logic early_ff;
    logic nxt_early;
    logic cdb_take;
    logic buf_in_valid;
    logic buf_in_ready;
    logic buf_out_valid;
    logic [8:0] buf_in_data;
    logic [8:0] buf_out_data;
    logic buf_push;
    logic last_beat;

    // =====================================================================
    // Command intake
    // =====================================================================
    // Only one command at a time: intake closes until status is taken
    assign cdb_ready_out = (state_ff == pmss_pkg::PMSS_IDLE) ||
                           (state_ff == pmss_pkg::PMSS_CDB);
    assign cdb_take = cdb_valid_in && cdb_ready_out;

    // =====================================================================
    // Command state
    // =====================================================================
    always_comb begin
        nxt_state = state_ff;
        nxt_idx = idx_ff;
        nxt_op = op_ff;
        nxt_b1 = b1_ff;
        nxt_alloc = alloc_ff;
        nxt_len = len_ff;
        nxt_stat = stat_ff;
        nxt_halt = 1'b0;
        nxt_discard = 1'b0;
        nxt_kept = kept_ff;
        case (state_ff)
            pmss_pkg::PMSS_IDLE, pmss_pkg::PMSS_CDB: begin
                if (cdb_take) begin
                    if (idx_ff == 3'd0) begin
                        nxt_op = cdb_data_in;
                    end
                    if (idx_ff == `PMSS_KEEP_BYTE) begin
                        nxt_b1 = cdb_data_in;
                    end
                    if (idx_ff == `PMSS_ALLOC_BYTE) begin
                        nxt_alloc = cdb_data_in;
                    end
                    if (idx_ff == CDB_LAST) begin
                        nxt_idx = 3'd0;
                        nxt_state = pmss_pkg::PMSS_EXEC;
                    end else begin
                        nxt_idx = idx_ff + 3'd1;
                        nxt_state = pmss_pkg::PMSS_CDB;
                    end
                end
            end
            pmss_pkg::PMSS_EXEC: begin
                nxt_stat = `PMSS_STAT_GOOD;
                // mode report answered in DATA IN
                if (op_ff == `PMSS_OP_MODE_REPORT) begin
                    nxt_len = pmss_min8(alloc_ff, AVAIL);
                    if (alloc_ff == 8'h00) begin
                        nxt_state = pmss_pkg::PMSS_STATUS;
                    end else begin
                        nxt_state = pmss_pkg::PMSS_DATA;
                    end
                // halt request to the print engine
                end else if (op_ff == `PMSS_OP_PRINT_HALT) begin
                    nxt_halt = 1'b1;
                    // keep bit picks discard or keep
                    nxt_discard = !b1_ff[`PMSS_KEEP_BIT];
                    nxt_kept = b1_ff[`PMSS_KEEP_BIT];
                    nxt_state = pmss_pkg::PMSS_STATUS;
                end else begin
                    // Unknown opcodes are refused, nothing else moves
                    nxt_stat = `PMSS_STAT_CHECK;
                    nxt_state = pmss_pkg::PMSS_STATUS;
                end
            end
            pmss_pkg::PMSS_DATA: begin
                if (buf_push && last_beat) begin
                    nxt_state = pmss_pkg::PMSS_DRAIN;
                end
            end
            pmss_pkg::PMSS_DRAIN: begin
                // Status waits until the last byte has left the buffer
                if (!buf_out_valid) begin
                    nxt_state = pmss_pkg::PMSS_STATUS;
                end
            end
            pmss_pkg::PMSS_STATUS: begin
                if (status_ready_in) begin
                    nxt_state = pmss_pkg::PMSS_IDLE;
                end
            end
            default: begin
                nxt_state = pmss_pkg::PMSS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state_ff <= pmss_pkg::PMSS_IDLE;
            idx_ff <= 3'd0;
            op_ff <= 8'h00;
            b1_ff <= 8'h00;
            alloc_ff <= 8'h00;
            len_ff <= 8'h00;
            stat_ff <= 8'h00;
            halt_ff <= 1'b0;
            discard_ff <= 1'b0;
            kept_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            idx_ff <= nxt_idx;
            op_ff <= nxt_op;
            b1_ff <= nxt_b1;
            alloc_ff <= nxt_alloc;
            len_ff <= nxt_len;
            stat_ff <= nxt_stat;
            halt_ff <= nxt_halt;
            discard_ff <= nxt_discard;
            kept_ff <= nxt_kept;
        end
    end

    // =====================================================================
    // Mode report stream
    // =====================================================================
    assign buf_in_valid = (state_ff == pmss_pkg::PMSS_DATA);
    // last byte of the trimmed count
    assign last_beat = (sent_ff == len_ff - 8'd1);
    assign buf_in_data = {last_beat, pmss_sense_byte(sent_ff, policy_ff, vendor_bytes_in)};
    assign buf_push = buf_in_valid && buf_in_ready;

    always_comb begin
        nxt_sent = sent_ff;
        if (state_ff == pmss_pkg::PMSS_EXEC) begin
            nxt_sent = 8'h00;
        end else if (buf_push) begin
            nxt_sent = sent_ff + 8'd1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            sent_ff <= 8'h00;
        end else begin
            sent_ff <= nxt_sent;
        end
    end

    // Buffer keeps a stalled byte; the last flag rides along
    pmss_skid #(
        .WIDTH(9)
    ) buf_u (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .in_data_in(buf_in_data),
        .in_valid_in(buf_in_valid),
        .in_ready_out(buf_in_ready),
        .out_data_out(buf_out_data),
        .out_valid_out(buf_out_valid),
        .out_ready_in(din_ready_in)
    );

    assign din_data_out = buf_out_data[7:0];
    assign din_last_out = buf_out_data[8];
    assign din_valid_out = buf_out_valid;

    // =====================================================================
    // Acknowledge policy
    // =====================================================================
    always_comb begin
        nxt_policy = policy_in;
        // policy zero waits for physical print
        // reserved values get no behaviour of their own
        nxt_early = (policy_in == `PMSS_POLICY_MAX);
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            policy_ff <= 3'h0;
            early_ff <= 1'b0;
        end else begin
            policy_ff <= nxt_policy;
            early_ff <= nxt_early;
        end
    end

    // =====================================================================
    // Outputs
    // =====================================================================
    assign status_valid_out = (state_ff == pmss_pkg::PMSS_STATUS);
    assign status_out = stat_ff;
    // engine stops where it can; halt is a one-cycle request
    assign halt_out = halt_ff;
    assign discard_out = discard_ff;
    // kept data stays available for recovery
    // sticky flag tells the engine leftovers print first
    assign keep_out = kept_ff;
    assign policy_out = policy_ff;
    assign print_ack_early_out = early_ff;
endmodule : pmss_core
`default_nettype wire

// file: design/pmss_map.svh
// Constants for the printer mode-report / print-halt command block
`ifndef PMSS_MAP_SVH
`define PMSS_MAP_SVH
`define PMSS_OP_MODE_REPORT 8'h1a
`define PMSS_OP_PRINT_HALT 8'h1b
`define PMSS_CDB_LEN 3'd6
`define PMSS_HDR_LEN 8'd4
`define PMSS_ALLOC_BYTE 3'd4
`define PMSS_KEEP_BYTE 3'd1
`define PMSS_KEEP_BIT 0
`define PMSS_POLICY_LSB 4
`define PMSS_POLICY_MAX 3'd1
`define PMSS_STAT_GOOD 8'h00
`define PMSS_STAT_CHECK 8'h02
`endif

// file: design/pmss_pkg.sv
// Types for the printer mode-report / print-halt command block
`default_nettype none
package pmss_pkg;
    typedef enum logic [2:0] {
        PMSS_IDLE,
        PMSS_CDB,
        PMSS_EXEC,
        PMSS_DATA,
        PMSS_DRAIN,
        PMSS_STATUS
    } pmss_state_t;
endpackage : pmss_pkg
`default_nettype wire

// file: design/pmss_skid.sv
// Two-entry buffer with valid/ready on both sides
`default_nettype none
module pmss_skid #(
    parameter int WIDTH = 8
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [WIDTH-1:0] in_data_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    output logic [WIDTH-1:0] out_data_out,
    output logic out_valid_out,
    input wire logic out_ready_in
);
    logic [WIDTH-1:0] mem_ff [2];
    logic [WIDTH-1:0] nxt_mem [2];
    logic rd_ff, wr_ff, nxt_rd, nxt_wr;
    logic [1:0] cnt_ff, nxt_cnt;
    logic push, pop;

    assign in_ready_out = (cnt_ff != 2'd2);
    assign out_valid_out = (cnt_ff != 2'd0);
    assign out_data_out = mem_ff[rd_ff];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    always_comb begin
        nxt_mem = mem_ff;
        nxt_rd = rd_ff;
        nxt_wr = wr_ff;
        nxt_cnt = cnt_ff;
        if (push) begin
            nxt_mem[wr_ff] = in_data_in;
            nxt_wr = ~wr_ff;
        end
        if (pop) begin
            nxt_rd = ~rd_ff;
        end
        if (push && !pop) begin
            nxt_cnt = cnt_ff + 2'd1;
        end else if (pop && !push) begin
            nxt_cnt = cnt_ff - 2'd1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            mem_ff[0] <= '0;
            mem_ff[1] <= '0;
            rd_ff <= 1'b0;
            wr_ff <= 1'b0;
            cnt_ff <= 2'd0;
        end else begin
            mem_ff <= nxt_mem;
            rd_ff <= nxt_rd;
            wr_ff <= nxt_wr;
            cnt_ff <= nxt_cnt;
        end
    end
endmodule : pmss_skid
`default_nettype wire

// file: tb/pmss_core_properties.sv
// Port checks for the printer command block
`default_nettype none
module pmss_core_properties (
    input wire logic clk_in, rst_n_in, din_valid_out, din_ready_in, status_valid_out,
    input wire logic halt_out, keep_out, discard_out, print_ack_early_out,
    input wire logic din_last_out, cdb_ready_out,
    input wire logic [7:0] din_data_out,
    input wire logic [2:0] policy_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence last_beat_s;
        din_valid_out && din_ready_in && din_last_out;
    endsequence
    sequence status_soon_s;
        ##[1:4] status_valid_out;
    endsequence
    status_after_a: assert property (last_beat_s |-> status_soon_s) else $error("no status");
    last_flag_a: assert property (din_last_out |-> din_valid_out) else $error("last");
    halt_pulse_a: assert property (halt_out |=> !halt_out) else $error("halt long");
    cdb_closed_a: assert property (status_valid_out |-> !cdb_ready_out) else $error("cdb");
    din_hold_a: assert property (din_valid_out && !din_ready_in |=> $stable(din_data_out))
        else $error("data lost");
    data_first_a: assert property (din_valid_out |-> !status_valid_out) else $error("overlap");
    early_ack_a: assert property (print_ack_early_out |-> policy_out == 3'h1) else $error("ack");
    halt_mode_a: assert property (halt_out |-> keep_out ^ discard_out) else $error("halt");
endmodule : pmss_core_properties
bind pmss_core pmss_core_properties chk_u (.*);
`default_nettype wire

// file: tb/pmss_init.sv
// Initiator model: sends command blocks, takes data and status
`default_nettype none
module pmss_init (
    input wire logic clk_in, cdb_ready_out, din_valid_out, status_valid_out,
    input wire logic [7:0] din_data_out, status_out,
    output logic [7:0] cdb_data_in,
    output logic cdb_valid_in, din_ready_in, status_ready_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] rx[$], st;
    logic slow = 1'b0, tog = 1'b0, done;
    // Stall every other cycle when slow
    assign din_ready_in = tog | !slow;
    assign status_ready_in = 1'b1;
    initial {cdb_valid_in, cdb_data_in} = 9'h0;
    always @(posedge clk_in) begin
        tog <= ~tog;
        if (din_valid_out && din_ready_in) rx.push_back(din_data_out);
        if (status_valid_out) {done, st} <= {1'b1, status_out};
    end
    task automatic cmd(input logic [7:0] op, b1, alloc);
        // Reserved bytes zero, length in byte 4
        logic [7:0] b[6] = '{op, b1, 8'h0, 8'h0, alloc, 8'h0};
        rx.delete();
        done = 1'b0;
        foreach (b[i]) begin
            {cdb_valid_in, cdb_data_in} = {1'b1, b[i]};
            do @(posedge clk_in); while (!cdb_ready_out);
            #1;
        end
        {cdb_valid_in, cdb_data_in} = {1'b0, ~cdb_data_in};
        while (!done) @(posedge clk_in);
        #1;
    endtask : cmd
endmodule : pmss_init
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench for the printer command block
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_in = 0, rst_n_in = 0, cdb_valid_in, cdb_ready_out, din_valid_out, din_ready_in;
    logic din_last_out, status_valid_out, status_ready_in, halt_out, discard_out, keep_out;
    logic print_ack_early_out;
    logic [7:0] cdb_data_in, din_data_out, status_out;
    logic [2:0] policy_in = 3'h1, policy_out;
    logic [23:0] vendor_bytes_in = 24'h5a3c96;
    int error_cnt = 0, checks_done = 0, cyc = 0, lasts = 0;
    logic [1:0] halt_seen = 2'b00;
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin error_cnt++; \
    $display("mismatch %0t %h %h", $time, a, e); end end
    pmss_core #(.VENDOR_BYTES(2)) dut_u (.*);
    pmss_init init_u (.*);
    initial forever #2 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        if (halt_out) halt_seen <= {keep_out, discard_out};
        if (din_valid_out && din_ready_in && din_last_out) lasts++;
    end
    always @(posedge clk_in) if (++cyc == 3000) begin error_cnt++; summarize(); end
    task automatic summarize();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : summarize
    task automatic sense(input logic [7:0] alloc, input int n);
        init_u.cmd(8'h1a, 8'h0, alloc);
        `CHK(init_u.rx.size(), n)
        `CHK(init_u.st, 8'h0)
        if (n > 2) `CHK({init_u.rx[0], init_u.rx[2]}, {8'h5, 1'b0, policy_in, 4'h0})
    endtask : sense
    initial begin
        repeat (6) @(posedge clk_in);
        #1 rst_n_in = 1;
        sense(8'h0, 0);
        sense(8'h3, 3);
        `CHK(print_ack_early_out, 1'b1)
        {init_u.slow, policy_in} = {1'b1, 3'h0};
        sense(8'hc8, 6);
        `CHK({init_u.rx[4], init_u.rx[5]}, 16'h963c)
        `CHK(print_ack_early_out, 1'b0)
        init_u.cmd(8'h1b, 8'h1, 8'h0);
        `CHK(init_u.st, 8'h0)
        `CHK(halt_seen, 2'b10)
        `CHK(keep_out, 1'b1)
        init_u.cmd(8'h1b, 8'h0, 8'h0);
        `CHK(halt_seen, 2'b01)
        `CHK(keep_out, 1'b0)
        init_u.cmd(8'h00, 8'h0, 8'h0);
        `CHK(init_u.st, 8'h02)
        sense(8'h6, 6);
        policy_in = 3'h5;
        sense(8'h4, 4);
        `CHK(print_ack_early_out, 1'b0)
        `CHK(policy_out, 3'h5)
        `CHK(lasts, 4)
        summarize();
    end
endmodule : tb_top
`default_nettype wire
